/* File: tcsr_defs.svh */
`ifndef TCSR_DEFS_SVH
`define TCSR_DEFS_SVH

// cause codes
`define TCSR_CAUSE_NONE    8'h00
`define TCSR_CAUSE_RESET   8'h01
`define TCSR_CAUSE_TIMEOUT 8'h2C
`define TCSR_CAUSE_ATN     8'h42
`define TCSR_CAUSE_ATN_MSG 8'h43
`define TCSR_CAUSE_ATN_BLK 8'h47
`define TCSR_CAUSE_NORMAL  8'h60
`define TCSR_CAUSE_L_ATN   8'h61
`define TCSR_CAUSE_L_MSG   8'h62
`define TCSR_CAUSE_L_BLK   8'h66

// step codes
`define TCSR_STEP_0 8'h00
`define TCSR_STEP_1 8'h01
`define TCSR_STEP_2 8'h02
`define TCSR_STEP_3 8'h03
`define TCSR_STEP_6 8'h06

`endif

/* File: tcsr_pkg.sv */
package tcsr_pkg;
	// command being run
	typedef enum logic [1:0] {
		TCSR_CMD_CLOSE,
		TCSR_CMD_LINKED,
		TCSR_CMD_RELEASE
	} tcsr_cmd_t;

	// sequence position
	typedef enum logic [2:0] {
		TCSR_ST_IDLE,
		TCSR_ST_FIRST,
		TCSR_ST_SECOND,
		TCSR_ST_ATN,
		TCSR_ST_AFTER
	} tcsr_state_t;
endpackage

/* File: tcsr_report.sv */
`timescale 1ns/1ps
`include "tcsr_defs.svh"

// Function
// - reset before any transfer reports cause 01H step 00H, all commands.
// - closing commands: reset in status is step 01H, message-in step 02H.
// - timeout stops at once: cause 2CH, step 01H status, 02H message-in.
// - reset or timeout ends the command in the detecting cycle; the attention state ignores both.
// - auto receipt off: attention after a phase gives 42H, phase step.
// - auto receipt on, one byte taken: 43H with phase step.
// - auto receipt on, buffer holds data: 47H with phase step.
// - auto receive mode selects between 42H and the 43H/47H codes.
// - linked, attention after message-in, auto off: 61H step 03H.
// - linked, attention after message-in, byte taken: 62H step 03H.
// - linked, attention after message-in, buffer blocked: 66H step 06H.
// - linked, attention after status gives 42H/43H/47H with step 01H.
// - release: reset while moving step 01H, after transfer step 02H.
// - release: timeout ends at once, cause 2CH step 01H.
// - release: attention outcomes after message-in all carry step 01H.
module tcsr_report (
	// clock and reset
	input  wire logic                core_clk,
	input  wire logic                rst,
	// command start
	input  wire logic                cmd_start,
	input  wire tcsr_pkg::tcsr_cmd_t cmd_kind,
	input  wire logic                auto_msg_rx_en,
	// phase sequencing from the transfer engine
	input  wire logic                phase_begin,
	input  wire logic                phase_done,
	input  wire logic                reqack_timeout,
	input  wire logic                msg_byte_taken,
	input  wire logic                msg_buf_blocked,
	// scsi pins, asynchronous
	input  wire logic                scsi_rst_pin,
	input  wire logic                scsi_atn_pin,
	// report to host
	output logic                     report_valid,
	output logic [7:0]               report_cause,
	output logic [7:0]               report_step,
	output logic                     busy,
	output logic                     phase_abort
);
	import tcsr_pkg::*;

	// ****************************************
	// pin synchronisers
	// ****************************************
	logic [2:0] rst_sync_q;
	logic [2:0] atn_sync_q;
	logic       rst_seen_q;
	logic       atn_seen_q;
	wire        rst_agree = rst_sync_q[1] == rst_sync_q[2];
	wire        atn_agree = atn_sync_q[1] == atn_sync_q[2];

	always_ff @(posedge core_clk) begin
		if (rst) begin
			rst_sync_q <= 3'h0;
			atn_sync_q <= 3'h0;
		end else begin
			rst_sync_q <= {rst_sync_q[1:0], scsi_rst_pin};
			atn_sync_q <= {atn_sync_q[1:0], scsi_atn_pin};
		end
	end

	// filtered levels only change once stages two and three agree
	always_ff @(posedge core_clk) begin
		if (rst) begin
			rst_seen_q <= 1'b0;
			atn_seen_q <= 1'b0;
		end else begin
			if (rst_agree)
				rst_seen_q <= rst_sync_q[2];
			if (atn_agree)
				atn_seen_q <= atn_sync_q[2];
		end
	end

	// ****************************************
	// sequence state
	// ****************************************
	tcsr_state_t state_q;
	tcsr_state_t state_d;
	tcsr_cmd_t   cmd_q;
	logic        auto_q;
	logic        moving_q;

	wire is_close   = cmd_q == TCSR_CMD_CLOSE;
	wire is_linked  = cmd_q == TCSR_CMD_LINKED;
	wire is_release = cmd_q == TCSR_CMD_RELEASE;
	wire active     = state_q != TCSR_ST_IDLE;
	// release has one moving phase; closing commands have two
	wire last_phase = is_release ? (state_q == TCSR_ST_FIRST)
	                             : (state_q == TCSR_ST_SECOND);
	wire in_phase   = state_q == TCSR_ST_FIRST
	               || state_q == TCSR_ST_SECOND;

	// ****************************************
	// outcome decode
	// ****************************************
	logic       fin;
	logic [7:0] cause_d;
	logic [7:0] step_d;

	// step for the phase in progress or just ended
	wire [7:0] phase_step = (state_q == TCSR_ST_SECOND)
	                        ? `TCSR_STEP_2 : `TCSR_STEP_1;
	// attention is judged against the phase that just closed
	logic atn_after_msg_q;

	// ****************************************
	// attention outcome decode
	// ****************************************
	// with auto receipt off the outcome is known at once
	wire       atn_ready = !auto_q || msg_byte_taken || msg_buf_blocked;
	// linked close-out after message-in has its own code family
	wire       atn_linked = is_linked && atn_after_msg_q;
	wire [7:0] atn_step_plain = (atn_after_msg_q && !is_release)
	                            ? `TCSR_STEP_2 : `TCSR_STEP_1;
	// plain codes
	// a blocked buffer outranks a taken byte
	wire [7:0] atn_cause_plain = !auto_q ? `TCSR_CAUSE_ATN
	                           : msg_buf_blocked ? `TCSR_CAUSE_ATN_BLK
	                           : `TCSR_CAUSE_ATN_MSG;
	wire [7:0] atn_cause_linked = !auto_q ? `TCSR_CAUSE_L_ATN
	                            : msg_buf_blocked ? `TCSR_CAUSE_L_BLK
	                            : `TCSR_CAUSE_L_MSG;
	wire [7:0] atn_step_linked = (auto_q && msg_buf_blocked)
	                             ? `TCSR_STEP_6 : `TCSR_STEP_3;
	wire [7:0] atn_cause = atn_linked ? atn_cause_linked : atn_cause_plain;
	wire [7:0] atn_step  = atn_linked ? atn_step_linked : atn_step_plain;

	always_comb begin
		state_d = state_q;
		fin     = 1'b0;
		cause_d = `TCSR_CAUSE_NONE;
		step_d  = `TCSR_STEP_0;
		unique case (state_q)
		TCSR_ST_IDLE: begin
			if (cmd_start)
				state_d = TCSR_ST_FIRST;
		end
		TCSR_ST_FIRST, TCSR_ST_SECOND: begin
			if (rst_seen_q && !moving_q && state_q == TCSR_ST_FIRST) begin
				fin     = 1'b1;
				cause_d = `TCSR_CAUSE_RESET;
				step_d  = `TCSR_STEP_0;
			end else if (rst_seen_q) begin
				fin     = 1'b1;
				cause_d = `TCSR_CAUSE_RESET;
				step_d  = phase_step;
			end else if (reqack_timeout) begin
				fin     = 1'b1;
				cause_d = `TCSR_CAUSE_TIMEOUT;
				step_d  = phase_step;
			end else if (phase_done) begin
				if (atn_seen_q)
					state_d = TCSR_ST_ATN;
				else if (!last_phase)
					state_d = TCSR_ST_SECOND;
				else if (is_release)
					state_d = TCSR_ST_AFTER;
				else begin
					fin     = 1'b1;
					cause_d = `TCSR_CAUSE_NORMAL;
					step_d  = `TCSR_STEP_3;
				end
			end
		end
		TCSR_ST_ATN: begin
			if (atn_ready) begin
				fin     = 1'b1;
				cause_d = atn_cause;
				step_d  = atn_step;
			end
		end
		TCSR_ST_AFTER: begin
			if (rst_seen_q) begin
				fin     = 1'b1;
				cause_d = `TCSR_CAUSE_RESET;
				step_d  = `TCSR_STEP_2;
			end else begin
				fin     = 1'b1;
				cause_d = `TCSR_CAUSE_NORMAL;
				step_d  = `TCSR_STEP_2;
			end
		end
		// unused codes fall back to idle rather than lock up
		default: begin
			state_d = TCSR_ST_IDLE;
		end
		endcase
		if (fin)
			state_d = TCSR_ST_IDLE;
	end

	// ****************************************
	// registers
	// ****************************************
	always_ff @(posedge core_clk) begin
		if (rst) begin
			state_q  <= TCSR_ST_IDLE;
			cmd_q    <= TCSR_CMD_CLOSE;
			auto_q   <= 1'b0;
			moving_q <= 1'b0;
			atn_after_msg_q <= 1'b0;
		end else begin
			state_q <= state_d;
			if (state_q == TCSR_ST_IDLE && cmd_start) begin
				cmd_q  <= cmd_kind;
				// mode latched at start so a mid-command write cannot split
				auto_q <= auto_msg_rx_en;
			end
			if (!in_phase)
				moving_q <= 1'b0;
			else if (phase_begin)
				moving_q <= 1'b1;
			if (in_phase && phase_done)
				atn_after_msg_q <= state_q == TCSR_ST_SECOND || is_release;
		end
	end

	// cause and step held until the next report; valid pulses for one cycle
	always_ff @(posedge core_clk) begin
		if (rst) begin
			report_valid <= 1'b0;
			report_cause <= `TCSR_CAUSE_NONE;
			report_step  <= `TCSR_STEP_0;
			busy         <= 1'b0;
			phase_abort  <= 1'b0;
		end else begin
			report_valid <= fin;
			busy         <= state_d != TCSR_ST_IDLE;
			phase_abort  <= fin && in_phase
			                && (rst_seen_q || reqack_timeout);
			if (fin) begin
				report_cause <= cause_d;
				report_step  <= step_d;
			end
		end
	end

	wire unused_ok = active | is_close;
endmodule

/* File: tcsr_sva.sv */
`timescale 1ns/1ps
module tcsr_sva (
	// clock and reset
	input wire logic       core_clk,
	input wire logic       rst,
	// causes
	input wire logic       cmd_start,
	input wire logic       reqack_timeout,
	// report
	input wire logic       report_valid,
	input wire logic [7:0] report_cause,
	input wire logic [7:0] report_step,
	input wire logic       busy,
	input wire logic       phase_abort
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);
	wire [7:0] cc = report_cause;
	wire [7:0] st = report_step;
	wire       rv = report_valid;
	// ****
	// report properties
	// ****
	sequence s_tmo; busy && reqack_timeout; endsequence
	sequence s_end; rv && phase_abort && !busy; endsequence
	property p_tmo; s_tmo |=> s_end; endproperty
	a_tmo: assert property (p_tmo) else $error("timeout late");
	property p_abrt; rv && phase_abort |-> cc inside {8'h01, 8'h2C};
	endproperty
	a_abrt: assert property (p_abrt) else $error("bad abort");
	property p_norm; rv && cc == 8'h60 |-> !phase_abort && st > 8'h01;
	endproperty
	a_norm: assert property (p_norm) else $error("bad end");
	property p_att; rv && cc inside {8'h42, 8'h43, 8'h47} |-> st < 8'h03;
	endproperty
	a_att: assert property (p_att) else $error("bad atn");
	property p_link; rv && cc inside {8'h61, 8'h62} |-> st == 8'h03;
	endproperty
	a_link: assert property (p_link) else $error("bad link");
	property p_blk; rv && cc == 8'h66 |-> st == 8'h06; endproperty
	a_blk: assert property (p_blk) else $error("bad block");
	property p_hold; !rv |-> $stable(cc) && $stable(st); endproperty
	a_hold: assert property (p_hold) else $error("code moved");
	property p_start; cmd_start && !busy |=> busy; endproperty
	a_start: assert property (p_start) else $error("no start");
endmodule
bind tcsr_report tcsr_sva tcsr_sva_i (.core_clk, .rst, .cmd_start,
	.reqack_timeout, .report_valid, .report_cause, .report_step, .busy,
	.phase_abort);

/* File: tcsr_init.sv */
`timescale 1ns/1ps
module tcsr_init (
	// clock
	input wire logic core_clk,
	// bench requests
	input wire logic rst_req,
	input wire logic atn_req,
	// scsi pins
	output logic     scsi_rst_pin,
	output logic     scsi_atn_pin
);
	// ****
	// initiator pins
	// ****
	always_ff @(posedge core_clk) begin
		scsi_rst_pin <= rst_req;
		scsi_atn_pin <= atn_req;
	end
endmodule

/* File: tcsr_report_tb_top.sv */
`timescale 1ns/1ps
module tcsr_report_tb_top;
	import tcsr_pkg::*;
	logic core_clk = 0, rst = 1, cmd_start = 0, auto_msg_rx_en = 0;
	logic phase_begin = 0, phase_done = 0, reqack_timeout = 0;
	logic msg_byte_taken = 0, msg_buf_blocked = 0, rst_req = 0, atn_req = 0;
	logic scsi_rst_pin, scsi_atn_pin, report_valid, busy, phase_abort;
	logic [7:0] report_cause, report_step;
	tcsr_cmd_t cmd_kind = TCSR_CMD_CLOSE;
	int n_errors = 0, n_compared = 0;
	always #50 core_clk = ~core_clk;
	tcsr_init tcsr_init_i (.core_clk, .rst_req, .atn_req, .scsi_rst_pin,
		.scsi_atn_pin);
	tcsr_report tcsr_report_i (.core_clk, .rst, .cmd_start, .cmd_kind,
		.auto_msg_rx_en, .phase_begin, .phase_done, .reqack_timeout,
		.msg_byte_taken, .msg_buf_blocked, .scsi_rst_pin, .scsi_atn_pin,
		.report_valid, .report_cause, .report_step, .busy, .phase_abort);
	// ****
	// model and checks
	// ****
	task automatic results;
		$display("compared %0d errors %0d", n_compared, n_errors);
		if (n_errors == 0 && n_compared > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task automatic cmp(input logic [17:0] got, input logic [17:0] exp);
		n_compared++;
		if (got !== exp) begin
			n_errors++;
			$display("mismatch t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	function automatic logic [16:0] model(int k, int a, int e, int x);
		logic [7:0] c, s;
		case (e)
			0: return 17'h10100;
			1: return 17'h10101;
			2: return 17'h10102;
			3: return 17'h12C01;
			4: return 17'h12C02;
			7: return {9'h060, k == 2 ? 8'h02 : 8'h03};
			8: return 17'h00102;
		endcase
		c = a == 0 ? 8'h42 : x == 2 ? 8'h47 : 8'h43;
		s = e == 5 ? 8'h01 : 8'h02;
		if (e == 6 && k == 1) begin
			c = a == 0 ? 8'h61 : x == 2 ? 8'h66 : 8'h62;
			s = a && x == 2 ? 8'h06 : 8'h03;
		end
		return {1'b0, c, s};
	endfunction
	task automatic tick(int n);
		repeat (n) @(posedge core_clk);
	endtask
	// e: 0 early reset, 1-2 reset, 3-4 timeout, 5-6 atn, 7 normal,
	// 8 reset seen just after the release transfer ends
	task automatic run(int k, int a, int e, int x);
		int p;
		tick($urandom % 4 + 1);
		cmd_start <= 1;
		cmd_kind <= tcsr_cmd_t'(k);
		auto_msg_rx_en <= a[0];
		tick(1);
		cmd_start <= 0;
		rst_req <= e == 0;
		for (p = 1; p <= (k == 2 ? 1 : 2) && e != 0; p++) begin
			tick(1);
			phase_begin <= 1;
			// start while busy must be ignored, mode is latched
			cmd_start <= 1;
			cmd_kind <= tcsr_cmd_t'($urandom % 3);
			auto_msg_rx_en <= 1'($urandom);
			tick(1);
			phase_begin <= 0;
			cmd_start <= 0;
			rst_req <= e == p || e == 8;
			reqack_timeout <= e == p + 2;
			atn_req <= e == p + 4;
			tick(1);
			reqack_timeout <= 0;
			if (e == p || e == p + 2)
				break;
			// long enough for attention to pass the synchroniser
			// for e 8 the phase ends one edge before reset is seen
			tick(e == 8 ? 3 : 6);
			phase_done <= 1;
			tick(1);
			phase_done <= 0;
			if (e == p + 4)
				break;
		end
		if (a && e > 4) begin
			tick(1);
			msg_byte_taken <= x == 1;
			msg_buf_blocked <= x == 2;
		end
		for (p = 0; p < 40 && report_valid !== 1'b1; p++)
			@(negedge core_clk);
		cmp({report_valid, phase_abort, report_cause, report_step},
			{1'b1, model(k, a, e, x)});
		tick(1);
		{rst_req, atn_req, msg_byte_taken, msg_buf_blocked} <= 4'h0;
		tick(10);
		$display("test kind %0d event %0d rx %0d done", k, e, x);
	endtask
	initial begin
		int k, x;
		void'($urandom(32'h1BE0));
		tick(2);
		rst <= 0;
		for (k = 0; k < 3; k++) begin
			run(k, 0, 0, 0);
			run(k, 0, 1, 0);
			if (k < 2)
				run(k, 0, 2, 0);
			run(k, 0, 3, 0);
			if (k < 2)
				run(k, 0, 4, 0);
			for (x = 0; x < 3; x++) begin
				run(k, x > 0, 5, x);
				if (k < 2)
					run(k, x > 0, 6, x);
			end
			run(k, 0, 7, 0);
			if (k == 2)
				run(k, 0, 8, 0);
		end
		results();
	end
	initial begin
		#2ms;
		n_errors++;
		results();
	end
endmodule
